// *** logic/cbt_pkg.sv ***
// package: constants for the external bus cycle sequencer
package cbt_pkg;
  localparam int unsigned data_width      = 16;
  localparam int unsigned phase_count     = 8;
  localparam logic [2:0]  phase_first     = 3'h0;
  localparam logic [2:0]  phase_last      = 3'h7;
  // internal phase five counted from zero, phase six counted from one
  localparam logic [2:0]  phase_stretch   = 3'h5;
  localparam logic [2:0]  phase_pullup    = 3'h7;
  localparam logic [2:0]  phase_addr_on   = 3'h1;
  localparam logic [2:0]  phase_addr_off  = 3'h6;
  localparam logic [2:0]  phase_strb_on   = 3'h2;
  localparam logic [2:0]  phase_strb_off  = 3'h5;
  // write data outlasts its strobe by one clock period, two phases
  localparam logic [2:0]  phase_wdata_off = 3'h7;
  localparam int unsigned shift_base_m    = 5;
  localparam int unsigned shift_per_n_m   = 3;
  localparam logic [6:0]  shift_max_n     = 7'h7F;
  localparam int unsigned intr_latency_m  = 7;
  localparam logic [15:0] data_reset      = 16'h0000;
  localparam logic [9:0]  cycle_cnt_reset = 10'h000;
endpackage

// *** logic/cbt_phase_gen.sv ***
// eight-phase machine cycle generator with stretch handling
`timescale 1ns/10ps
module cbt_phase_gen (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       stretch,
  output logic [2:0]      phase,
  output logic            cycle_end,
  output logic            held
);
  logic stretching;
  logic second_half;

  // phase six samples stretch every machine cycle, bus busy or not
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stretching  <= 1'b0;
      second_half <= 1'b0;
    end else if (phase == cbt_pkg::phase_stretch && !stretching) begin
      stretching  <= stretch;
      second_half <= 1'b0;
    end else if (held) begin
      // a clock period is two phases: release only after an even count
      second_half <= !second_half;
      if (second_half && !stretch) begin
        stretching <= 1'b0;
      end
    end
  end

  // one extra clock period minimum, one more per further period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= cbt_pkg::phase_first;
    end else if (phase == cbt_pkg::phase_stretch + 3'h1 && stretching) begin
      phase <= phase;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  assign held      = stretching && (phase == cbt_pkg::phase_stretch + 3'h1);
  assign cycle_end = (phase == cbt_pkg::phase_last);
endmodule // cbt_phase_gen

// *** logic/cbt_bus_seq.sv ***
// bus cycle sequencer: address, read and write phases on shared lines
// Contract
// - all address and data travel on one set of sixteen shared lines
// - address valid one phase before address strobe, held one after
// - address drivers released throughout the read data interval
// - write data valid at strobe lead, held one period after trail
// - minimal stretch adds one period, n more periods add n plus one
// - stretch sampled at every phase six, transfer or not
// - each machine cycle runs through eight phases, pull-ups in one
// - shift by n takes five plus three n cycles plus read stretch
// - interrupt answered within seven cycles plus read stretch
`timescale 1ns/10ps
module cbt_bus_seq (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        stretch,
  input  wire logic [15:0] data_in,
  input  wire logic        shift_start,
  input  wire logic [6:0]  shift_n,
  input  wire logic        intr_req,
  output logic [15:0]      data_out,
  output logic             data_oe,
  output logic             address_strobe_n,
  output logic             read_data_strobe,
  output logic             write_data_strobe,
  output logic             pullup_en,
  output logic             busy,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic             shift_done,
  output logic             intr_ack
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    cbt_idle_type  = 2'b00,
    cbt_addr_type  = 2'b01,
    cbt_data_type  = 2'b10
  } cbt_state_type;

  cbt_state_type state;
  cbt_state_type next_state;
  logic [2:0]    phase;
  logic          cycle_end;
  logic          held;
  logic          is_write;
  logic [15:0]   addr;
  logic [15:0]   wdata;
  logic [9:0]    shift_left;
  logic          shift_run;
  logic [2:0]    intr_left;
  logic          intr_run;

  cbt_phase_gen u_phase (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .stretch   (stretch),
    .phase     (phase),
    .cycle_end (cycle_end),
    .held      (held)
  );

  function automatic logic in_phase(input logic [2:0] p,
                                    input logic [2:0] lo,
                                    input logic [2:0] hi);
    in_phase = (p >= lo) && (p <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // transfers start only at a machine cycle boundary
  always_comb begin
    next_state = state;
    unique case (state)
      cbt_idle_type: if (cycle_end && req) next_state = cbt_addr_type;
      cbt_addr_type: if (cycle_end) next_state = cbt_data_type;
      cbt_data_type: if (cycle_end) next_state = cbt_idle_type;
      default:       next_state = cbt_idle_type;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= cbt_idle_type;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      is_write <= 1'b0;
      addr     <= cbt_pkg::data_reset;
      wdata    <= cbt_pkg::data_reset;
    end else if (state == cbt_idle_type && cycle_end && req) begin
      is_write <= req_write;
      addr     <= req_addr;
      wdata    <= req_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next cycle's phase, so outputs stay straight from flip-flops
  logic [2:0] np;
  logic       in_addr;
  logic       in_data;
  logic       addr_win;
  logic       strb_win;
  logic       wdat_win;
  assign np       = held ? phase : phase + 3'h1;
  assign in_addr  = (next_state == cbt_addr_type);
  assign in_data  = (next_state == cbt_data_type);
  assign addr_win = in_phase(np, cbt_pkg::phase_addr_on,
                             cbt_pkg::phase_addr_off);
  assign strb_win = in_phase(np, cbt_pkg::phase_strb_on,
                             cbt_pkg::phase_strb_off);
  // a clock period spans two phases, so write data runs on to phase 7
  assign wdat_win = in_phase(np, cbt_pkg::phase_strb_on,
                             cbt_pkg::phase_wdata_off);

  // address 1..6, strobe 2..5: one phase margin each side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      address_strobe_n  <= 1'b1;
      read_data_strobe  <= 1'b0;
      write_data_strobe <= 1'b0;
      data_oe           <= 1'b0;
      data_out          <= cbt_pkg::data_reset;
    end else begin
      address_strobe_n  <= !(in_addr && strb_win);
      read_data_strobe  <= in_data && !is_write && strb_win;
      write_data_strobe <= in_data && is_write && strb_win;
      // read interval leaves the lines undriven
      if (in_addr && addr_win) begin
        data_oe  <= 1'b1;
        data_out <= addr;
      end else if (in_data && is_write && wdat_win) begin
        data_oe  <= 1'b1;
        data_out <= wdata;
      end else begin
        data_oe  <= 1'b0;
        data_out <= data_out;
      end
    end
  end

  // responder data is good by the strobe's end, capture there
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= cbt_pkg::data_reset;
    end else begin
      rd_valid <= read_data_strobe && !(in_data && !is_write && strb_win);
      if (read_data_strobe) begin
        rd_data <= data_in;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pullup_en <= 1'b0;
      busy      <= 1'b0;
    end else begin
      pullup_en <= (np == cbt_pkg::phase_pullup);
      busy      <= (next_state != cbt_idle_type);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift timing: 5+3n machine cycles, stretch adds the read extension
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_left <= cbt_pkg::cycle_cnt_reset;
      shift_run  <= 1'b0;
      shift_done <= 1'b0;
    end else begin
      shift_done <= 1'b0;
      if (!shift_run && shift_start && shift_n != 7'h00) begin
        shift_run  <= 1'b1;
        shift_left <= 10'(cbt_pkg::shift_base_m)
                      + 10'(cbt_pkg::shift_per_n_m) * {3'h0, shift_n};
      end else if (shift_run && cycle_end && !held) begin
        if (shift_left == 10'h001) begin
          shift_run  <= 1'b0;
          shift_done <= 1'b1;
        end
        shift_left <= shift_left - 10'h001;
      end
    end
  end

  // interrupt acknowledged after seven machine cycles; stretch only delays
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intr_left <= 3'h0;
      intr_run  <= 1'b0;
      intr_ack  <= 1'b0;
    end else begin
      intr_ack <= 1'b0;
      if (!intr_run && intr_req && !intr_ack) begin
        intr_run  <= 1'b1;
        intr_left <= 3'(cbt_pkg::intr_latency_m);
      end else if (intr_run && cycle_end && !held) begin
        if (intr_left == 3'h1) begin
          intr_run <= 1'b0;
          intr_ack <= 1'b1;
        end
        intr_left <= intr_left - 3'h1;
      end
    end
  end
endmodule // cbt_bus_seq

// *** dv/cbt_bus_seq_asserts.sv ***
// checker: bus cycle timing relations at the sequencer ports
`timescale 1ns/10ps
module cbt_bus_seq_asserts (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic        address_strobe_n,
  input wire logic        read_data_strobe,
  input wire logic        write_data_strobe,
  input wire logic        pullup_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // four clocks of address strobe, phases two to five
  sequence addr_phase;
    $fell(address_strobe_n) ##0 !address_strobe_n [*4];
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_addr_lead: assert property ($fell(address_strobe_n) |->
    $past(data_oe) && $stable(data_out)) else $error("address not ahead");
  a_addr_hold: assert property ($rose(address_strobe_n) |->
    data_oe && $stable(data_out)) else $error("address not held");
  a_strobe_width: assert property (addr_phase |=> address_strobe_n)
    else $error("address strobe width");
  a_one_data: assert property (addr_phase |=> address_strobe_n
    throughout (##[1:300] ($rose(read_data_strobe) ||
    $rose(write_data_strobe)))) else $error("no data phase");
  a_read_free: assert property (read_data_strobe |-> !data_oe)
    else $error("lines driven during read");
  a_write_lead: assert property ($rose(write_data_strobe) |-> data_oe)
    else $error("write data late");
  a_write_hold: assert property ($fell(write_data_strobe) |->
    data_oe && $stable(data_out) ##1 data_oe && $stable(data_out))
    else $error("write data not held");
  a_pullup_gap: assert property (pullup_en |=> !pullup_en [*7]
    ##[1:64] pullup_en) else $error("phase cycle length");
endmodule // cbt_bus_seq_asserts
bind cbt_bus_seq cbt_bus_seq_asserts i_chk (.sys_clk, .rst, .data_out,
  .data_oe, .address_strobe_n, .read_data_strobe, .write_data_strobe,
  .pullup_en);

// *** dv/cbt_mem_model.sv ***
// partner: memory on the shared lines, answering the data strobes
`timescale 1ns/10ps
module cbt_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        slow,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        address_strobe_n,
  input  wire logic        read_data_strobe,
  input  wire logic        write_data_strobe,
  output logic      [15:0] data_in
);
  logic [15:0] mem [0:65535];
  logic [15:0] addr;
  logic [15:0] last = 16'h5A5A;
  logic [2:0]  rd_age;
  logic [1:0]  wr_seen;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!address_strobe_n) addr <= data_out;
    rd_age <= read_data_strobe ? rd_age + 3'h1 : 3'h0;
    wr_seen <= {wr_seen[0], write_data_strobe};
    // taken two clocks after the strobe trails; undriven lines corrupt it
    if (wr_seen == 2'b10 && !write_data_strobe)
      mem[addr] <= data_oe ? data_out : ~data_out;
    last <= data_in;
  end
  // slow answers only in the last strobe clock; undriven lines toggle
  always_comb begin
    if (read_data_strobe && (!slow || rd_age > 3'h2))
      data_in = mem[addr];
    else if (data_oe)
      data_in = data_out;
    else
      data_in = ~last;
  end
endmodule // cbt_mem_model

// *** dv/cbt_bus_seq_test.sv ***
// testbench: bus sequencer against a memory model
`timescale 1ns/10ps
module cbt_bus_seq_test;
  logic        sys_clk, rst, req, req_write, stretch, slow, shift_start;
  logic        intr_req, data_oe, address_strobe_n, read_data_strobe;
  logic        write_data_strobe, pullup_en, busy, rd_valid, shift_done;
  logic        intr_ack;
  logic [15:0] req_addr, req_wdata, data_in, data_out, rd_data;
  logic [6:0]  shift_n;
  int          errors, compares, n, e, rnd, seed = 1632;
  //////////////////////////////////////////////////////////////////////////
  cbt_bus_seq i_dut (.sys_clk, .rst, .req, .req_write, .req_addr,
    .req_wdata, .stretch, .data_in, .shift_start, .shift_n, .intr_req,
    .data_out, .data_oe, .address_strobe_n, .read_data_strobe,
    .write_data_strobe, .pullup_en, .busy, .rd_valid, .rd_data,
    .shift_done, .intr_ack);
  cbt_mem_model i_mem (.sys_clk, .slow, .data_out, .data_oe,
    .address_strobe_n, .read_data_strobe, .write_data_strobe, .data_in);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic int shift_clk(input logic [6:0] sn);
    return (5 + 3 * int'(sn)) * 8;
  endfunction
  // a stretch seen over k phase clocks covers whole periods of two phases
  function automatic int stretch_clk(input int k);
    return k == 0 ? 0 : 2 * ((k + 1) / 2);
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait; random stretch pulses only while rnd is set
  task automatic wait_sig(ref logic sig, input logic val, input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (rnd != 0) stretch <= ($random(seed) & 7) == 0;
    end while (sig !== val && n < lim);
    if (sig !== val) begin
      errors++;
      tally_and_finish();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {req, req_write, stretch, slow, shift_start, intr_req} = 6'h00;
    {req_addr, req_wdata} = 32'h0000_0000;
    shift_n = 7'h01;
    rnd = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    check("idle", {12'h000, address_strobe_n, read_data_strobe,
      write_data_strobe, data_oe}, 16'h0008);
    for (int k = 0; k < 5; k++) begin
      wait_sig(pullup_en, 1'b1, 20);
      repeat (5) @(posedge sys_clk);
      if (k > 0) stretch <= 1'b1;
      repeat (k) @(posedge sys_clk);
      stretch <= 1'b0;
      wait_sig(pullup_en, 1'b1, 40);
      check("cycle len", 16'(5 + k + n),
            16'(8 + stretch_clk(k)));
    end
    $display("phase test done");
    rnd = 1;
    for (int i = 0; i < 16; i++) begin
      req_write <= ~i[0];
      slow <= 1'($random(seed));
      if (!i[0]) begin
        req_addr <= i == 0 ? 16'h0000 : i == 2 ? 16'hFFFF : 16'($random(seed));
        req_wdata <= 16'($random(seed));
      end
      req <= 1'b1;
      wait_sig(busy, 1'b1, 40);
      req <= 1'b0;
      if (i[0]) begin
        wait_sig(rd_valid, 1'b1, 80);
        check("read data", rd_data, req_wdata);
      end
      wait_sig(busy, 1'b0, 80);
    end
    rnd = 0;
    @(posedge sys_clk);
    stretch <= 1'b0;
    // read once more, then hold stretch in the idle cycle to block the bus
    req_write <= 1'b0;
    req <= 1'b1;
    wait_sig(busy, 1'b1, 40);
    req <= 1'b0;
    wait_sig(rd_valid, 1'b1, 80);
    check("read again", rd_data, req_wdata);
    stretch <= 1'b1;
    repeat (9) @(posedge sys_clk);
    check("blocked", {15'h0000, pullup_en}, 16'h0000);
    stretch <= 1'b0;
    wait_sig(busy, 1'b0, 80);
    $display("transfer test done");
    for (int j = 0; j < 3; j++) begin
      shift_n <= j == 0 ? 7'h01 : j == 1 ? 7'h7F
                 : 7'($random(seed) & 63) + 7'h02;
      shift_start <= 1'b1;
      @(posedge sys_clk);
      shift_start <= 1'b0;
      e = shift_clk(shift_n);
      wait_sig(shift_done, 1'b1, 4000);
      check("shift time", 16'(n > e - 9 && n < e + 9), 16'h0001);
    end
    intr_req <= 1'b1;
    wait_sig(intr_ack, 1'b1, 200);
    intr_req <= 1'b0;
    check("intr wait", 16'(n > 47 && n < 66), 16'h0001);
    $display("shift and interrupt tests done");
    tally_and_finish();
  end
endmodule // cbt_bus_seq_test
